/* common/ffr_pkg.sv */
/*
  Constants and carrier types for the fieldbus to fibre repeater.
  Assumes a single 100 MHz device clock and synchronous pin inputs.
*/
package ffr_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned IDLE_BASE_S   = 5;
  localparam int unsigned IDLE_BASE_CYC = CLK_HZ * IDLE_BASE_S;
  localparam int unsigned IDLE_TBIT_CNT = 65535;
  localparam int unsigned FE_MAX_NS     = 300;
  localparam int unsigned FF_MAX_NS     = 1300;
  localparam int unsigned EF_EXTRA_NS   = 1000;
  localparam int unsigned FE_MAX_CYC    = FE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned FF_MAX_CYC    = FF_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned EF_EXTRA_CYC  = EF_EXTRA_NS / CLK_PERIOD_NS;
  localparam int unsigned FLASH_CYC     = 25_000_000;
  localparam int unsigned RX_IND_CYC    = 5_000_000;

  // ----------------------------------------------------------------------
  // Bit rates and frame format
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_RATES = 10;
  localparam int unsigned RATE_W    = 4;
  localparam int unsigned PER_W     = 14;
  localparam int unsigned RATE_BPS [NUM_RATES] = '{
    9600, 19200, 45450, 93750, 187500, 500000, 1500000, 3000000, 6000000, 12000000};
  localparam int unsigned HUNT_EDGES      = 16;
  localparam int unsigned GLITCH_CYC      = 3;
  localparam int unsigned CHAR_BITS       = 11;
  localparam int unsigned FRAME_GAP_BITS  = 11;
  localparam int unsigned DRIVE_HOLD_BITS = 2;
  localparam int unsigned GAP_W           = 17;
  localparam logic [7:0]  SD1 = 8'h10;
  localparam logic [7:0]  SD2 = 8'h68;
  localparam logic [7:0]  SD3 = 8'ha2;
  localparam logic [7:0]  SD4 = 8'hdc;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONFIG      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS      = 4'h4;
  localparam int unsigned CFG_END_UNIT_BIT = 0;
  localparam int unsigned CFG_RING_BIT     = 1;
  localparam int unsigned CFG_FOCAL_BIT    = 2;
  localparam int unsigned CFG_IDLE_LSB     = 3;
  localparam int unsigned CFG_LOST_LSB     = 8;
  localparam logic [1:0]  CFG_IDLE_RST     = 2'h0;
  localparam logic [4:0]  CFG_LOST_RST     = 5'h1f;
  localparam int unsigned ST_BUS_ACT_BIT   = 0;
  localparam int unsigned ST_RATE_OK_BIT   = 1;
  localparam int unsigned ST_RATE_LSB      = 2;
  localparam int unsigned ST_LOCAL_BIT     = 6;
  localparam int unsigned ST_REMOTE_BIT    = 7;
  localparam int unsigned ST_CH1_UP_BIT    = 8;
  localparam int unsigned ST_CH2_UP_BIT    = 9;
  localparam int unsigned ST_DUAL_BIT      = 10;
  localparam int unsigned ST_LOST_LSB      = 11;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] lost_limit;
    logic [1:0] idle_sel;
    logic       focal;
    logic       ring;
    logic       end_unit;
  } ffr_cfg_s;

  typedef struct packed {
    logic ch1;
    logic ch2;
    logic link_fault;
    logic local_fault;
    logic remote_fault;
    logic bus_active;
    logic elec_rx;
    logic opt_rx;
  } ffr_led_s;

endpackage

/* hdl/ffr_repeater.sv */
/*
  Fieldbus to fibre converter and repeater: rate detection, retiming,
  optical repeating, ring switch-over and link indicators.
  Assumes all pins synchronous to mclk_i; optical power and peer
  handshake status come from the transceiver and link framing outside.
*/
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module ffr_repeater #(
  parameter int unsigned IDLE_UNIT_CYC = ffr_pkg::IDLE_BASE_CYC,
  parameter int unsigned FLASH_HALF    = ffr_pkg::FLASH_CYC,
  parameter int unsigned RX_IND_HOLD   = ffr_pkg::RX_IND_CYC
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  // Register port
  input  wire logic [3:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  // Electrical bus
  input  wire logic             elec_rx_i,
  output logic                  elec_tx_o,
  output logic                  elec_oe_n_o,
  // Optical channels
  input  wire logic             opt1_rx_i,
  input  wire logic             opt2_rx_i,
  input  wire logic             opt1_power_i,
  input  wire logic             opt2_power_i,
  input  wire logic             opt1_peer_ok_i,
  input  wire logic             opt2_peer_ok_i,
  input  wire logic             remote_fault_rpt_i,
  output logic                  opt1_tx_o,
  output logic                  opt2_tx_o,
  // Indicators
  output ffr_pkg::ffr_led_s     led_o
);
  import ffr_pkg::*;

  localparam int unsigned FL_W = $clog2(FLASH_HALF + 1);
  localparam int unsigned RI_W = $clog2(RX_IND_HOLD + 1);

  typedef enum logic [0:0] {DET_HUNT, DET_LOCK} ffr_det_e;

  function automatic logic [PER_W-1:0] rate_period(input logic [RATE_W-1:0] idx);
    rate_period = PER_W'(CLK_HZ / RATE_BPS[idx]);
  endfunction

  function automatic logic [RATE_W-1:0] classify(input logic [PER_W-1:0] run);
    int unsigned d;
    int unsigned best_d;
    best_d   = 32'hffffffff;
    classify = '0;
    for (int i = 0; i < NUM_RATES; i++) begin
      d = (run > rate_period(RATE_W'(i))) ? run - rate_period(RATE_W'(i))
                                          : rate_period(RATE_W'(i)) - run;
      if (d < best_d) begin
        best_d   = d;
        classify = RATE_W'(i);
      end
    end
  endfunction

  function automatic logic led_state(input logic up, input logic power, input logic blink);
    led_state = up | (power & blink);
  endfunction

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  ffr_cfg_s cfg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cfg.end_unit   <= 1'b0;
      cfg.ring       <= 1'b0;
      cfg.focal      <= 1'b0;
      cfg.idle_sel   <= CFG_IDLE_RST;
      cfg.lost_limit <= CFG_LOST_RST;
    end else if (reg_wr_i && reg_addr_i == ADDR_CONFIG) begin
      cfg.end_unit   <= reg_wdata_i[CFG_END_UNIT_BIT];
      cfg.ring       <= reg_wdata_i[CFG_RING_BIT];
      cfg.focal      <= reg_wdata_i[CFG_FOCAL_BIT];
      cfg.idle_sel   <= reg_wdata_i[CFG_IDLE_LSB +: 2];
      cfg.lost_limit <= reg_wdata_i[CFG_LOST_LSB +: 5];
    end
  end

  // ----------------------------------------------------------------------
  // Link supervision
  // ----------------------------------------------------------------------
  logic ch1_up;
  logic ch2_up;
  logic local_fault;
  logic remote_fault;
  logic focal_ring;
  logic dual_tx;

  assign ch1_up     = opt1_power_i & opt1_peer_ok_i;
  assign ch2_up     = opt2_power_i & opt2_peer_ok_i;
  assign focal_ring = cfg.ring & cfg.focal;
  // An end unit has only one pair, so the unused channel is no fault.
  assign local_fault = cfg.end_unit ? !(ch1_up | ch2_up) : !(ch1_up & ch2_up);
  assign remote_fault = remote_fault_rpt_i
                      | (cfg.end_unit & !opt1_power_i & !opt2_power_i);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dual_tx <= 1'b0;
    end else begin
      dual_tx <= focal_ring & (local_fault | remote_fault_rpt_i);
    end
  end

  // ----------------------------------------------------------------------
  // Data paths
  // ----------------------------------------------------------------------
  ffr_det_e          det_state;
  logic [RATE_W-1:0] rate_idx;
  logic              rate_valid;
  logic [PER_W-1:0]  period;
  logic              opt_in;
  logic              repeat_en;
  logic [15:0]       drive_cnt;
  logic              elec_gated;
  logic              elec_q;
  logic              elec_qq;
  logic [PER_W-1:0]  ret_phase;
  logic              ret_bit;

  assign rate_valid = (det_state == DET_LOCK);
  assign period     = rate_valid ? rate_period(rate_idx) : rate_period('0);
  // The focal point listens on channel one only while the ring is whole,
  // which keeps the ring from circulating its own traffic.
  assign opt_in     = (focal_ring && !dual_tx) ? opt1_rx_i : (opt1_rx_i & opt2_rx_i);
  assign repeat_en  = !focal_ring;
  assign elec_gated = (drive_cnt != '0) ? 1'b1 : elec_rx_i;

  // Fibre data drives the bus; the driver is held a little past the last
  // low bit so the own transmission is not heard back as bus traffic.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      drive_cnt   <= '0;
      elec_tx_o   <= 1'b1;
      elec_oe_n_o <= 1'b1;
    end else begin
      if (!opt_in) begin
        drive_cnt <= 16'(period * DRIVE_HOLD_BITS);
      end else if (drive_cnt != '0) begin
        drive_cnt <= drive_cnt - 16'h0001;
      end
      elec_tx_o   <= opt_in;
      elec_oe_n_o <= !(!opt_in || drive_cnt != '0);
    end
  end

  // Electrical input is oversampled at the device clock; once the rate is locked the bit phase is
  // realigned at every edge and each bit is resampled at mid-bit.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      elec_q    <= 1'b1;
      elec_qq   <= 1'b1;
      ret_phase <= '0;
      ret_bit   <= 1'b1;
    end else begin
      elec_q  <= elec_gated;
      elec_qq <= elec_q;
      if (!rate_valid) begin
        ret_phase <= '0;
        ret_bit   <= elec_q;
      end else if (elec_q != elec_qq) begin
        ret_phase <= period >> 1;
      end else if (ret_phase == '0) begin
        ret_phase <= period - 1'b1;
        ret_bit   <= elec_q;
      end else begin
        ret_phase <= ret_phase - 1'b1;
      end
    end
  end

  // Wired-AND merge: idle is high, so a low from either source passes.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      opt1_tx_o <= 1'b1;
      opt2_tx_o <= 1'b1;
    end else begin
      opt1_tx_o <= ret_bit & (repeat_en ? opt2_rx_i : 1'b1);
      opt2_tx_o <= ((!focal_ring || dual_tx) ? ret_bit : 1'b1)
                 & (repeat_en ? opt1_rx_i : 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // Rate detection and delimiter supervision
  // ----------------------------------------------------------------------
  logic              line_mon;
  logic              line_prev;
  logic [PER_W-1:0]  run_cnt;
  logic [PER_W-1:0]  min_run;
  logic [4:0]        edge_cnt;
  logic              ur_busy;
  logic              ur_first;
  logic [PER_W-1:0]  ur_phase;
  logic [3:0]        ur_bitn;
  logic [10:0]       ur_shift;
  logic [10:0]       next_char;
  logic [GAP_W-1:0]  gap_cnt;
  logic              gap_full;
  logic              char_end;
  logic              sd_ok;
  logic              sd_bad;
  logic [4:0]        lost_cnt;
  logic [31:0]       idle_cnt;
  logic [31:0]       idle_limit;
  logic              restart;
  logic              bus_active;

  assign line_mon  = elec_q & opt_in;
  assign next_char = {line_mon, ur_shift[10:1]};
  assign char_end  = ur_busy && ur_phase == '0 && ur_bitn == 4'(CHAR_BITS - 1);
  assign gap_full  = gap_cnt >= GAP_W'(period * FRAME_GAP_BITS);
  assign sd_ok  = char_end && ur_first && !next_char[0] && next_char[10]
               && (next_char[8:1] == SD1 || next_char[8:1] == SD2
                || next_char[8:1] == SD3 || next_char[8:1] == SD4);
  assign sd_bad = char_end && ur_first && !sd_ok;

  always_comb begin
    unique case (cfg.idle_sel)
      2'h0: idle_limit = IDLE_UNIT_CYC;
      2'h1: idle_limit = IDLE_UNIT_CYC * 2;
      2'h2: idle_limit = IDLE_UNIT_CYC * 4;
      2'h3: idle_limit = 32'(IDLE_TBIT_CNT * period);
    endcase
  end

  assign restart = rate_valid && ((lost_cnt >= cfg.lost_limit && lost_cnt != '0)
                || idle_cnt >= idle_limit);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      line_prev <= 1'b1;
      // Start saturated: the quiet time before reset is no bit time.
      run_cnt   <= '1;
    end else begin
      line_prev <= line_mon;
      if (line_mon != line_prev) begin
        run_cnt <= '0;
      end else if (run_cnt != '1) begin
        run_cnt <= run_cnt + 1'b1;
      end
    end
  end

  // The shortest clean run between edges is one bit time.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      det_state <= DET_HUNT;
      min_run   <= '1;
      edge_cnt  <= '0;
      rate_idx  <= '0;
    end else begin
      unique case (det_state)
        DET_HUNT: begin
          if (line_mon != line_prev && run_cnt >= PER_W'(GLITCH_CYC)) begin
            min_run  <= (run_cnt < min_run) ? run_cnt : min_run;
            edge_cnt <= edge_cnt + 1'b1;
          end
          if (edge_cnt == 5'(HUNT_EDGES)) begin
            rate_idx  <= classify(min_run);
            det_state <= DET_LOCK;
          end
        end
        DET_LOCK: begin
          if (restart) begin
            det_state <= DET_HUNT;
            min_run   <= '1;
            edge_cnt  <= '0;
          end
        end
      endcase
    end
  end

  // Character receiver; only the first character after a frame gap is
  // checked for a start delimiter.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !rate_valid) begin
      ur_busy  <= 1'b0;
      ur_first <= 1'b0;
      ur_phase <= '0;
      ur_bitn  <= '0;
      ur_shift <= '1;
      gap_cnt  <= '0;
    end else begin
      if (ur_busy || !line_mon) begin
        gap_cnt <= '0;
      end else if (!gap_full) begin
        gap_cnt <= gap_cnt + 1'b1;
      end
      if (!ur_busy) begin
        if (line_prev && !line_mon) begin
          ur_busy  <= 1'b1;
          ur_first <= gap_full;
          ur_phase <= period >> 1;
          ur_bitn  <= '0;
        end
      end else if (ur_phase == '0) begin
        ur_shift <= next_char;
        ur_phase <= period - 1'b1;
        ur_bitn  <= ur_bitn + 1'b1;
        if (char_end) begin
          ur_busy <= 1'b0;
        end
      end else begin
        ur_phase <= ur_phase - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !rate_valid || restart) begin
      lost_cnt   <= '0;
      idle_cnt   <= '0;
      bus_active <= 1'b0;
    end else begin
      if (sd_ok) begin
        lost_cnt   <= '0;
        idle_cnt   <= '0;
        bus_active <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + 32'h00000001;
        if (sd_bad && lost_cnt != '1) begin
          lost_cnt <= lost_cnt + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------------
  logic [FL_W-1:0] flash_cnt;
  logic            blink;
  logic [RI_W-1:0] elec_ind_cnt;
  logic [RI_W-1:0] opt_ind_cnt;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flash_cnt <= '0;
      blink     <= 1'b0;
    end else if (flash_cnt == FL_W'(FLASH_HALF - 1)) begin
      flash_cnt <= '0;
      blink     <= !blink;
    end else begin
      flash_cnt <= flash_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      elec_ind_cnt <= '0;
      opt_ind_cnt  <= '0;
    end else begin
      elec_ind_cnt <= !elec_q ? RI_W'(RX_IND_HOLD)
                    : (elec_ind_cnt != '0) ? elec_ind_cnt - 1'b1 : elec_ind_cnt;
      opt_ind_cnt  <= !opt_in ? RI_W'(RX_IND_HOLD)
                    : (opt_ind_cnt != '0) ? opt_ind_cnt - 1'b1 : opt_ind_cnt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      led_o <= '0;
    end else begin
      led_o.ch1          <= led_state(ch1_up, opt1_power_i, blink);
      led_o.ch2          <= led_state(ch2_up, opt2_power_i, blink);
      led_o.link_fault   <= local_fault;
      led_o.local_fault  <= local_fault;
      led_o.remote_fault <= remote_fault;
      led_o.bus_active   <= bus_active & rate_valid;
      led_o.elec_rx      <= elec_ind_cnt != '0;
      led_o.opt_rx       <= opt_ind_cnt != '0;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      unique case (reg_addr_i)
        ADDR_CONFIG: begin
          reg_rdata_o[CFG_END_UNIT_BIT]       <= cfg.end_unit;
          reg_rdata_o[CFG_RING_BIT]           <= cfg.ring;
          reg_rdata_o[CFG_FOCAL_BIT]          <= cfg.focal;
          reg_rdata_o[CFG_IDLE_LSB +: 2]      <= cfg.idle_sel;
          reg_rdata_o[CFG_LOST_LSB +: 5]      <= cfg.lost_limit;
        end
        ADDR_STATUS: begin
          reg_rdata_o[ST_BUS_ACT_BIT]         <= bus_active;
          reg_rdata_o[ST_RATE_OK_BIT]         <= rate_valid;
          reg_rdata_o[ST_RATE_LSB +: RATE_W]  <= rate_idx;
          reg_rdata_o[ST_LOCAL_BIT]           <= local_fault;
          reg_rdata_o[ST_REMOTE_BIT]          <= remote_fault;
          reg_rdata_o[ST_CH1_UP_BIT]          <= ch1_up;
          reg_rdata_o[ST_CH2_UP_BIT]          <= ch2_up;
          reg_rdata_o[ST_DUAL_BIT]            <= dual_tx;
          reg_rdata_o[ST_LOST_LSB +: 5]       <= lost_cnt;
        end
        default: begin
          reg_rdata_o <= '0;
        end
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule

/* testbench/ffr_repeater_props.sv */
/*
  Port checker for the fibre repeater: fibre paths and link indicators.
  Assumes it is bound into the repeater top and sees only its ports.
*/
`timescale 1ns/10ps
module ffr_repeater_props #(
  parameter int unsigned FLASH_HALF = 8
) (
  // Clock and reset
  input wire logic             mclk_i,
  input wire logic             sys_rst_i,
  // Optical side
  input wire logic             opt1_rx_i,
  input wire logic             opt1_power_i,
  input wire logic             opt2_power_i,
  input wire logic             opt1_peer_ok_i,
  input wire logic             opt2_peer_ok_i,
  input wire logic             remote_fault_rpt_i,
  // Outputs watched
  input wire logic             elec_tx_o,
  input wire logic             elec_oe_n_o,
  input wire ffr_pkg::ffr_led_s led_o
);
  import ffr_pkg::*;
  logic        prev_ch1;
  int unsigned run;
  logic        up1;
  logic        up2;
  assign up1 = opt1_power_i & opt1_peer_ok_i;
  assign up2 = opt2_power_i & opt2_peer_ok_i;
  // Counts how long the channel lamp stays unchanged while it must flash.
  always_ff @(posedge mclk_i) begin
    prev_ch1 <= led_o.ch1;
    if (sys_rst_i || !opt1_power_i || opt1_peer_ok_i || led_o.ch1 != prev_ch1) begin
      run <= 0;
    end else begin
      run <= run + 1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_drive_on;
    !elec_tx_o && !elec_oe_n_o;
  endsequence
  a_fibre_bus: assert property (!opt1_rx_i |=> s_drive_on)
    else $error("bus not driven low after fibre low");
  a_opt_rx_lamp: assert property (!opt1_rx_i |-> ##2 led_o.opt_rx)
    else $error("optical receive lamp dark after fibre low");
  a_link_lit: assert property (up1 |=> led_o.ch1)
    else $error("channel one lamp dark with link up");
  a_ch1_dark: assert property (!opt1_power_i |=> !led_o.ch1)
    else $error("channel one lamp on without power");
  a_ch2_dark: assert property (!opt2_power_i |=> !led_o.ch2)
    else $error("channel two lamp on without power");
  a_flash_pace: assert property (run <= FLASH_HALF + 2)
    else $error("channel one lamp not flashing");
  a_fault_pair: assert property (led_o.link_fault == led_o.local_fault)
    else $error("link fault and local fault differ");
  a_both_down: assert property (!up1 && !up2 |=> led_o.local_fault)
    else $error("local fault dark with both links down");
  a_remote_rpt: assert property (remote_fault_rpt_i |=> led_o.remote_fault)
    else $error("remote fault dark when reported");
  a_quiet_ok: assert property (up1 && up2 && !remote_fault_rpt_i |=>
    !led_o.local_fault && !led_o.remote_fault) else $error("fault lamp on with links up");
endmodule

bind ffr_repeater ffr_repeater_props #(.FLASH_HALF(FLASH_HALF)) ffr_repeater_props_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .opt1_rx_i(opt1_rx_i),
  .opt1_power_i(opt1_power_i), .opt2_power_i(opt2_power_i),
  .opt1_peer_ok_i(opt1_peer_ok_i), .opt2_peer_ok_i(opt2_peer_ok_i),
  .remote_fault_rpt_i(remote_fault_rpt_i), .elec_tx_o(elec_tx_o),
  .elec_oe_n_o(elec_oe_n_o), .led_o(led_o)
);

/* testbench/ffr_station.sv */
/*
  Fieldbus station model: sends one 11-bit character, LSB first.
  Assumes a terminated bus line that rests high when released.
*/
`timescale 1ns/10ps
module ffr_station #(
  parameter int unsigned PERIOD = 66
) (
  // Clock and request
  input  wire logic       mclk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  // Bus line
  output logic            line_o,
  output logic            busy_o
);
  logic [10:0] shift;
  int unsigned cnt;
  int unsigned left;
  initial begin
    busy_o = 1'b0;
  end
  // The released line returns to the termination level.
  assign line_o = busy_o ? shift[0] : 1'b1;
  always @(posedge mclk_i) begin
    if (!busy_o && go_i) begin
      shift  <= {1'b1, ^byte_i, byte_i, 1'b0};
      cnt    <= PERIOD;
      left   <= 11;
      busy_o <= 1'b1;
    end else if (busy_o && cnt > 1) begin
      cnt <= cnt - 1;
    end else if (busy_o) begin
      shift  <= shift >> 1;
      cnt    <= PERIOD;
      left   <= left - 1;
      busy_o <= left > 1;
    end
  end
endmodule

/* testbench/testbench.sv */
/*
  Self-checking bench for the fieldbus to fibre repeater.
  Assumes the port checker is bound from its own file.
*/
`timescale 1ns/10ps
module testbench;
  import ffr_pkg::*;
  localparam int unsigned PER = CLK_HZ / RATE_BPS[6];
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        opt1_rx_i = 1'b1, opt2_rx_i = 1'b1, p1 = 1'b1, p2 = 1'b1;
  logic        k1 = 1'b1, k2 = 1'b1, rpt = 1'b0, go = 1'b0;
  logic [7:0]  sbyte = 8'h0;
  logic [31:0] reg_rdata_o;
  logic        elec_rx_i, elec_tx_o, elec_oe_n_o, opt1_tx_o, opt2_tx_o, busy;
  ffr_led_s    led_o;
  int          n_mismatch = 0;
  int          n_compared = 0;
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  ffr_station #(.PERIOD(PER)) ffr_station_inst (.mclk_i(mclk_i), .go_i(go),
    .byte_i(sbyte), .line_o(elec_rx_i), .busy_o(busy));
  ffr_repeater #(.IDLE_UNIT_CYC(4000), .FLASH_HALF(8), .RX_IND_HOLD(16)) ffr_repeater_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .elec_rx_i(elec_rx_i), .elec_tx_o(elec_tx_o),
    .elec_oe_n_o(elec_oe_n_o), .opt1_rx_i(opt1_rx_i), .opt2_rx_i(opt2_rx_i),
    .opt1_power_i(p1), .opt2_power_i(p2), .opt1_peer_ok_i(k1), .opt2_peer_ok_i(k2),
    .remote_fault_rpt_i(rpt), .opt1_tx_o(opt1_tx_o), .opt2_tx_o(opt2_tx_o), .led_o(led_o));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic send(input logic [7:0] b);
    int i;
    @(posedge mclk_i);
    go <= 1'b1;
    sbyte <= b;
    @(posedge mclk_i);
    go <= 1'b0;
    #1;
    for (i = 0; i < 1000 && busy; i++) @(posedge mclk_i);
    if (busy) begin
      n_mismatch++;
      test_done();
    end
  endtask
  // Drives the optical status lines, then compares the lamps three cycles on when pk[4] is set.
  task automatic lamps(input logic [4:0] pk, input logic r, input logic [4:0] exp);
    @(posedge mclk_i);
    {p1, p2, k1, k2} <= pk[3:0];
    rpt <= r;
    tick(3);
    #1;
    if (pk[4]) chk("lamps", led_o[7:3], exp);
  endtask
  task automatic pulse(input bit ch2);
    @(posedge mclk_i);
    opt1_rx_i <= ch2;
    opt2_rx_i <= !ch2;
    @(posedge mclk_i);
    opt1_rx_i <= 1'b1;
    opt2_rx_i <= 1'b1;
    #1;
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rd(ADDR_CONFIG, d);
    chk("config reset", d, 32'h1f00);
    wr(ADDR_CONFIG, 32'hffff_ffff);
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd(ADDR_CONFIG, d);
    chk("config fields", d, 32'h1f1f);
    rd(ADDR_STATUS, d);
    chk("status dual", d[10], 1'b0);
    rd(4'h8, d);
    chk("unmapped", d, 32'h0);
    wr(ADDR_CONFIG, 32'h1f00);
    $display("t_regs done");
  endtask
  task automatic t_rate();
    logic [31:0] s;
    int i;
    repeat (4) send(SD2);
    tick(20 * PER);
    fork
      send(SD2);
      begin
        i = 0;
        #1;
        while (opt1_tx_o && i < 400) begin
          @(posedge mclk_i);
          #1;
          i++;
        end
        chk("bus to fibre latency", i <= PER + EF_EXTRA_CYC + 2, 1'b1);
        chk("repeat onward", opt2_tx_o, 1'b0);
        chk("bus rx lamp", led_o.elec_rx, 1'b1);
      end
    join
    tick(2);
    rd(ADDR_STATUS, s);
    chk("rate found", s[1:0], 2'b11);
    chk("rate index", s[5:2], 4'd6);
    tick(1000);
    chk("still active", led_o.bus_active, 1'b1);
    for (i = 0; i < 4000 && led_o.bus_active; i++) @(posedge mclk_i);
    chk("idle restart", led_o.bus_active, 1'b0);
    $display("t_rate done");
  endtask
  task automatic t_paths();
    pulse(1'b1);
    chk("repeat to ch1", opt1_tx_o, 1'b0);
    chk("fibre to bus", elec_tx_o, 1'b0);
    pulse(1'b0);
    chk("repeat to ch2", opt2_tx_o, 1'b0);
    $display("t_paths done");
  endtask
  task automatic t_leds();
    logic s0 = 1'b0;
    logic s1 = 1'b0;
    lamps(5'h1f, 1'b0, 5'b11000);
    lamps(5'h0d, 1'b0, 5'h00);
    repeat (24) begin
      @(posedge mclk_i);
      s1 |= led_o.ch1;
      s0 |= !led_o.ch1;
    end
    chk("flash", {s1, s0, led_o.local_fault}, 3'b111);
    lamps(5'h15, 1'b0, 5'b01110);
    wr(ADDR_CONFIG, 32'h1f01);
    lamps(5'h1a, 1'b0, 5'b10000);
    lamps(5'h10, 1'b0, 5'b00111);
    lamps(5'h1f, 1'b1, 5'b11001);
    lamps(5'h0f, 1'b0, 5'h00);
    $display("t_leds done");
  endtask
  task automatic t_ring();
    logic [31:0] s;
    wr(ADDR_CONFIG, 32'h1f06);
    pulse(1'b1);
    chk("loop broken", {elec_tx_o, opt1_tx_o}, 2'b11);
    lamps(5'h0e, 1'b0, 5'h00);
    rd(ADDR_STATUS, s);
    chk("dual send", s[10], 1'b1);
    pulse(1'b1);
    chk("ch2 heard", elec_tx_o, 1'b0);
    $display("t_ring done");
  endtask
  initial begin
    tick(16);
    sys_rst_i <= 1'b0;
    t_regs();
    t_rate();
    t_paths();
    t_leds();
    t_ring();
    tick(4);
    test_done();
  end
endmodule
